// [core/csb_regs.svh]
// Purpose: Timing and sizing constants of the socket control block
// Assumes: Reference clock at 200 MHz
// Notes: Definitions only
`ifndef CSB_REGS_SVH
`define CSB_REGS_SVH

// ==========================================================
// Clock rates
`define CSB_REF_CLK_MHZ 200
`define CSB_SOCK_CLK_MHZ 33
// Half period of the socket clock in reference cycles (rounded down)
`define CSB_HALF_CYC (`CSB_REF_CLK_MHZ / (2 * `CSB_SOCK_CLK_MHZ))

// ==========================================================
// Clock run release window before the clock stops
`define CSB_CLKRUN_HOLD_NS 240
`define CSB_CLKRUN_HOLD_CYC ((`CSB_CLKRUN_HOLD_NS * `CSB_REF_CLK_MHZ + 999) / 1000)

// ==========================================================
// Socket clocks to wait for a target select before aborting
`define CSB_DEVSEL_TMO 5
`define CSB_NUM_SLOTS 2
`define CSB_PHASE_W 4

`endif

// [core/csb_pkg.sv]
// Purpose: Types shared by the socket control block
// Assumes: Nothing
// Notes: State enums are one-hot
`default_nettype none

package csb_pkg;

  // ==========================================================
  // Clock run states
  typedef enum logic [2:0] {
    CR_RUN     = 3'h1,
    CR_RELEASE = 3'h2,
    CR_STOPPED = 3'h4
  } csb_crun_t;

  // ==========================================================
  // Link side states
  typedef enum logic [5:0] {
    LK_IDLE   = 6'h01,
    LK_ADDR   = 6'h02,
    LK_DATA   = 6'h04,
    LK_TURN   = 6'h08,
    LK_TARGET = 6'h10,
    LK_WATCH  = 6'h20
  } csb_link_t;

  // ==========================================================
  // Card sensing results
  typedef enum logic [1:0] {
    CT_NONE    = 2'h0,
    CT_PARTIAL = 2'h1,
    CT_16BIT   = 2'h2,
    CT_32BIT   = 2'h3
  } csb_card_t;

  typedef enum logic [1:0] {
    CV_NONE = 2'h0,
    CV_5V   = 2'h1,
    CV_3V3  = 2'h2,
    CV_LOW  = 2'h3
  } csb_volt_t;

endpackage : csb_pkg

`default_nettype wire

// [core/csb_sync2.sv]
// Purpose: Two flip-flop synchroniser with asynchronous clear
// Assumes: clr is a flop output or a constant
// Notes: Also used as a reset release stage with d tied high
`default_nettype none

module csb_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic clr,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // ==========================================================
  // Only q may be read outside this module
  always_ff @(posedge clk or posedge clr) begin
    if (clr) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : csb_sync2

`default_nettype wire

// [core/csb_socket_ctrl.sv]
// Purpose: Socket clock, reset, framing, select, grant and sensing per slot
// Assumes: Host logic on ref_clk; link logic on the returned socket clock
// Notes: Host transfer inputs must be stable while xferBusy is high
`default_nettype none

`include "csb_regs.svh"

module csb_socket_ctrl
  import csb_pkg::*;
#(
  parameter int NUM_SLOTS = `CSB_NUM_SLOTS,
  parameter int PHASE_W = `CSB_PHASE_W
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [NUM_SLOTS-1:0] sockLinkClk,
  input wire logic [NUM_SLOTS-1:0] slotResetReq,
  input wire logic [NUM_SLOTS-1:0] clkStopReq,
  input wire logic [NUM_SLOTS-1:0] arbEnable,
  input wire logic [NUM_SLOTS-1:0] ownAddrHit,
  input wire logic [NUM_SLOTS-1:0] xferStart,
  input wire logic [NUM_SLOTS-1:0][PHASE_W-1:0] xferPhases,
  output wire logic [NUM_SLOTS-1:0] xferBusy,
  output wire logic [NUM_SLOTS-1:0] xferDone,
  output wire logic [NUM_SLOTS-1:0] xferAbort,
  output wire logic [NUM_SLOTS-1:0] cardIrq,
  output wire logic [NUM_SLOTS-1:0] statusChanged,
  output wire logic [NUM_SLOTS-1:0] speakerOutput,
  output wire logic [NUM_SLOTS-1:0][1:0] cardType,
  output wire logic [NUM_SLOTS-1:0][1:0] cardVolt,
  output wire logic [NUM_SLOTS-1:0] socketClock,
  output wire logic [NUM_SLOTS-1:0] socketResetN,
  input wire logic [NUM_SLOTS-1:0] clockRunLineIn,
  output wire logic [NUM_SLOTS-1:0] clockRunLineOut,
  output wire logic [NUM_SLOTS-1:0] clockRunLineOe,
  input wire logic [NUM_SLOTS-1:0] socketAudioIn,
  input wire logic [NUM_SLOTS-1:0] cardDetect1N,
  input wire logic [NUM_SLOTS-1:0] cardDetect2N,
  input wire logic [NUM_SLOTS-1:0] voltageSense1,
  input wire logic [NUM_SLOTS-1:0] voltageSense2,
  input wire logic [NUM_SLOTS-1:0] socketInterruptN,
  input wire logic [NUM_SLOTS-1:0] statusChangeLine,
  input wire logic [NUM_SLOTS-1:0] socketBusRequestN,
  input wire logic [NUM_SLOTS-1:0] cycleFrameNIn,
  output wire logic [NUM_SLOTS-1:0] cycleFrameNOut,
  output wire logic [NUM_SLOTS-1:0] cycleFrameNOe,
  input wire logic [NUM_SLOTS-1:0] initiatorReadyNIn,
  output wire logic [NUM_SLOTS-1:0] initiatorReadyNOut,
  output wire logic [NUM_SLOTS-1:0] initiatorReadyNOe,
  input wire logic [NUM_SLOTS-1:0] targetReadyNIn,
  output wire logic [NUM_SLOTS-1:0] targetReadyNOut,
  output wire logic [NUM_SLOTS-1:0] targetReadyNOe,
  input wire logic [NUM_SLOTS-1:0] targetSelectNIn,
  output wire logic [NUM_SLOTS-1:0] targetSelectNOut,
  output wire logic [NUM_SLOTS-1:0] targetSelectNOe,
  output wire logic [NUM_SLOTS-1:0] socketBusGrantN
);

  // ==========================================================
  // Card sensing decode
  function automatic csb_card_t decodeType(input logic cd1N, input logic cd2N,
                                           input logic vs1, input logic vs2);
    if (cd1N && cd2N) begin
      return CT_NONE;
    end else if (cd1N || cd2N) begin
      return CT_PARTIAL;
    end else begin
      return (vs1 ^ vs2) ? CT_32BIT : CT_16BIT;
    end
  endfunction : decodeType

  function automatic csb_volt_t decodeVolt(input logic cd1N, input logic cd2N,
                                           input logic vs1, input logic vs2);
    if (cd1N || cd2N) begin
      return CV_NONE;
    end else if (!vs1) begin
      return CV_3V3;
    end else begin
      return vs2 ? CV_5V : CV_LOW;
    end
  endfunction : decodeVolt

  // ==========================================================
  // One independent copy per slot
  for (genvar g = 0; g < NUM_SLOTS; g++) begin : gSlot
    csb_crun_t crState;
    csb_link_t lkState;
    logic hostRst_r;
    logic linkRstN;
    logic [9:0] refS;
    logic [2:0] linkS;
    logic crInS, audS, cd1S, cd2S, vs1S, vs2S, intS, stsS, lkBusyS, ackS;
    logic reqS, hitS, arbS;
    logic [3:0] divCnt_r;
    logic [7:0] holdCnt_r;
    logic sockClk_r, crOe_r, crOut_r;
    logic reqLvl_r, busy_r, done_r, hAbort_r;
    logic [PHASE_W-1:0] phases_r;
    logic irq_r, sts_r, spk_r;
    csb_card_t type_r;
    csb_volt_t volt_r;
    logic ack_r, lAbort_r, lkBusy_r, grantN_r;
    logic frameOut_r, frameOe_r, irdyOut_r, irdyOe_r;
    logic devselOut_r, devselOe_r, trdyOut_r, trdyOe_r;
    logic dsSeen_r;
    logic [2:0] dsCnt_r;
    logic [PHASE_W-1:0] left_r;
    logic pending, busIdle, phaseDone;

    // ==========================================================
    // Crossings; the async lines never feed logic unsynchronised
    csb_sync2 #(.W(10)) uRefSync (
      .clk(ref_clk),
      .clr(1'h0),
      .d({clockRunLineIn[g], socketAudioIn[g], cardDetect1N[g], cardDetect2N[g],
          voltageSense1[g], voltageSense2[g], socketInterruptN[g],
          statusChangeLine[g], lkBusy_r, ack_r}),
      .q(refS)
    );
    assign {crInS, audS, cd1S, cd2S, vs1S, vs2S, intS, stsS, lkBusyS, ackS} = refS;

    csb_sync2 #(.W(3)) uLinkSync (
      .clk(sockLinkClk[g]),
      .clr(1'h0),
      .d({reqLvl_r, ownAddrHit[g], arbEnable[g]}),
      .q(linkS)
    );
    assign {reqS, hitS, arbS} = linkS;

    // Clear acts at once, release waits two socket clock edges
    csb_sync2 #(.W(1)) uRstRel (
      .clk(sockLinkClk[g]),
      .clr(hostRst_r),
      .d(1'h1),
      .q(linkRstN)
    );

    always_ff @(posedge ref_clk) begin
      hostRst_r <= sys_rst | slotResetReq[g];
    end

    // ==========================================================
    // Socket clock divider and clock run
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        divCnt_r <= 4'h0;
        sockClk_r <= 1'h0;
      end else if (divCnt_r == 4'(`CSB_HALF_CYC - 1)) begin
        divCnt_r <= 4'h0;
        // A high phase always completes, so the clock only parks low
        if (sockClk_r) begin
          sockClk_r <= 1'h0;
        end else if (crState != CR_STOPPED) begin
          sockClk_r <= 1'h1;
        end
      end else begin
        divCnt_r <= divCnt_r + 4'h1;
      end
    end

    // The window outlasts the synchroniser, so our own low drive is never seen as a request
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        crState <= CR_RUN;
        holdCnt_r <= 8'h0;
      end else begin
        case (crState)
          CR_RUN: begin
            holdCnt_r <= 8'h0;
            if (clkStopReq[g] && !lkBusyS) begin
              crState <= CR_RELEASE;
            end
          end
          CR_RELEASE: begin
            if (!clkStopReq[g]) begin
              crState <= CR_RUN;
            end else if (holdCnt_r == 8'(`CSB_CLKRUN_HOLD_CYC - 1)) begin
              crState <= crInS ? CR_STOPPED : CR_RUN;
            end else begin
              holdCnt_r <= holdCnt_r + 8'h1;
            end
          end
          CR_STOPPED: begin
            if (!crInS || !clkStopReq[g]) begin
              crState <= CR_RUN;
            end
          end
          default: begin
            crState <= CR_RUN;
          end
        endcase
      end
    end

    // Released line is the announcement that the clock goes down
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        crOe_r <= 1'h0;
        crOut_r <= 1'h0;
      end else begin
        crOe_r <= (crState == CR_RUN);
        crOut_r <= 1'h0;
      end
    end

    // ==========================================================
    // Host transfer handshake; the link reads phases_r while req is high
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        reqLvl_r <= 1'h0;
        busy_r <= 1'h0;
        done_r <= 1'h0;
        hAbort_r <= 1'h0;
        phases_r <= '0;
      end else begin
        done_r <= 1'h0;
        if (!busy_r && xferStart[g]) begin
          busy_r <= 1'h1;
          reqLvl_r <= 1'h1;
          phases_r <= xferPhases[g];
        end else if (reqLvl_r && ackS) begin
          reqLvl_r <= 1'h0;
          done_r <= 1'h1;
          hAbort_r <= lAbort_r;
        end else if (busy_r && !reqLvl_r && !ackS) begin
          busy_r <= 1'h0;
        end
      end
    end

    // ==========================================================
    // Status, audio and sensing
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        irq_r <= 1'h0;
        sts_r <= 1'h0;
        spk_r <= 1'h0;
        type_r <= CT_NONE;
        volt_r <= CV_NONE;
      end else begin
        irq_r <= !intS;
        sts_r <= stsS;
        spk_r <= audS;
        type_r <= decodeType(cd1S, cd2S, vs1S, vs2S);
        volt_r <= decodeVolt(cd1S, cd2S, vs1S, vs2S);
      end
    end

    // ==========================================================
    // Link side: pins are read straight at the rising edge
    assign pending = reqS && !ack_r;
    assign busIdle = cycleFrameNIn[g] && initiatorReadyNIn[g];
    assign phaseDone = !initiatorReadyNIn[g] && !targetReadyNIn[g];

    // The lock line has no port at all, so it is neither driven nor sampled
    always_ff @(posedge sockLinkClk[g]) begin
      if (!linkRstN) begin
        lkState <= LK_IDLE;
        left_r <= '0;
        dsCnt_r <= 3'h0;
        dsSeen_r <= 1'h0;
        ack_r <= 1'h0;
        lAbort_r <= 1'h0;
        frameOut_r <= 1'h1;
        frameOe_r <= 1'h0;
        irdyOut_r <= 1'h1;
        irdyOe_r <= 1'h0;
        devselOut_r <= 1'h1;
        devselOe_r <= 1'h0;
        trdyOut_r <= 1'h1;
        trdyOe_r <= 1'h0;
      end else begin
        if (!reqS) begin
          ack_r <= 1'h0;
        end
        case (lkState)
          LK_IDLE: begin
            if (pending && grantN_r && busIdle) begin
              lkState <= LK_ADDR;
              frameOe_r <= 1'h1;
              frameOut_r <= 1'h0;
              irdyOe_r <= 1'h1;
              irdyOut_r <= 1'h1;
              lAbort_r <= 1'h0;
              left_r <= (phases_r == '0) ? PHASE_W'(1) : phases_r;
            end else if (!cycleFrameNIn[g]) begin
              if (hitS) begin
                lkState <= LK_TARGET;
                devselOe_r <= 1'h1;
                devselOut_r <= 1'h0;
                trdyOe_r <= 1'h1;
                trdyOut_r <= 1'h0;
              end else begin
                lkState <= LK_WATCH;
              end
            end
          end
          LK_ADDR: begin
            lkState <= LK_DATA;
            irdyOut_r <= 1'h0;
            dsCnt_r <= 3'h0;
            dsSeen_r <= 1'h0;
            if (left_r == PHASE_W'(1)) begin
              frameOut_r <= 1'h1;
            end
          end
          LK_DATA: begin
            if (!targetSelectNIn[g]) begin
              dsSeen_r <= 1'h1;
            end
            if (!dsSeen_r && targetSelectNIn[g] && dsCnt_r == 3'(`CSB_DEVSEL_TMO - 1)) begin
              lkState <= LK_TURN;
              lAbort_r <= 1'h1;
              frameOut_r <= 1'h1;
              irdyOut_r <= 1'h1;
            end else begin
              if (!dsSeen_r && targetSelectNIn[g]) begin
                dsCnt_r <= dsCnt_r + 3'h1;
              end
              if (phaseDone) begin
                if (frameOut_r) begin
                  lkState <= LK_TURN;
                  irdyOut_r <= 1'h1;
                end else begin
                  left_r <= left_r - PHASE_W'(1);
                  if (left_r == PHASE_W'(2)) begin
                    frameOut_r <= 1'h1;
                  end
                end
              end
            end
          end
          LK_TARGET: begin
            // Frame already high at completion means this was the last phase
            if (phaseDone && cycleFrameNIn[g]) begin
              lkState <= LK_TURN;
              devselOut_r <= 1'h1;
              trdyOut_r <= 1'h1;
            end
          end
          LK_WATCH: begin
            if (busIdle) begin
              lkState <= LK_IDLE;
            end
          end
          LK_TURN: begin
            // One cycle driven high before release keeps the lines from floating low
            lkState <= LK_IDLE;
            if (frameOe_r) begin
              ack_r <= 1'h1;
            end
            frameOe_r <= 1'h0;
            irdyOe_r <= 1'h0;
            devselOe_r <= 1'h0;
            trdyOe_r <= 1'h0;
          end
          default: begin
            lkState <= LK_IDLE;
          end
        endcase
      end
    end

    // ==========================================================
    // Arbiter; our own pending transfer outranks the card
    always_ff @(posedge sockLinkClk[g]) begin
      if (!linkRstN) begin
        grantN_r <= 1'h1;
        lkBusy_r <= 1'h0;
      end else begin
        lkBusy_r <= (lkState != LK_IDLE) || pending || !busIdle;
        if (socketBusRequestN[g] || !arbS || pending) begin
          grantN_r <= 1'h1;
        end else if (busIdle && lkState == LK_IDLE) begin
          grantN_r <= 1'h0;
        end
      end
    end

    // ==========================================================
    // Outputs
    assign xferBusy[g] = busy_r;
    assign xferDone[g] = done_r;
    assign xferAbort[g] = hAbort_r;
    assign cardIrq[g] = irq_r;
    assign statusChanged[g] = sts_r;
    assign speakerOutput[g] = spk_r;
    assign cardType[g] = type_r;
    assign cardVolt[g] = volt_r;
    assign socketClock[g] = sockClk_r;
    assign socketResetN[g] = linkRstN;
    assign clockRunLineOut[g] = crOut_r;
    assign clockRunLineOe[g] = crOe_r;
    assign cycleFrameNOut[g] = frameOut_r;
    assign cycleFrameNOe[g] = frameOe_r;
    assign initiatorReadyNOut[g] = irdyOut_r;
    assign initiatorReadyNOe[g] = irdyOe_r;
    assign targetReadyNOut[g] = trdyOut_r;
    assign targetReadyNOe[g] = trdyOe_r;
    assign targetSelectNOut[g] = devselOut_r;
    assign targetSelectNOe[g] = devselOe_r;
    assign socketBusGrantN[g] = grantN_r;

    // ==========================================================
    // Checks
    AST_CLK_HALF: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(sockClk_r) |-> sockClk_r [*3] ##1 !sockClk_r)
      else $error("socket clock high phase wrong");
    AST_CLK_PARK_LOW: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (crState == CR_STOPPED) [*4] |-> !sockClk_r)
      else $error("socket clock stopped high");
    AST_CLKRUN_WAKE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (crState == CR_STOPPED && !crInS) |=> crState == CR_RUN)
      else $error("clock run request ignored");
    AST_RST_ASYNC: assert property (@(posedge ref_clk) disable iff (sys_rst)
      hostRst_r |-> !linkRstN)
      else $error("socket reset not asserted");
    AST_RST_RELEASE: assert property (@(posedge sockLinkClk[g]) disable iff (sys_rst)
      (!linkRstN && !$past(linkRstN)) |-> !(frameOe_r | irdyOe_r | devselOe_r | trdyOe_r))
      else $error("pin driven during socket reset");
    AST_AUDIO: assert property (@(posedge ref_clk) disable iff (sys_rst)
      socketAudioIn[g] [*4] |=> speakerOutput[g])
      else $error("audio not forwarded");
    AST_DETECT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (cardDetect1N[g] && cardDetect2N[g]) [*4] |=> (type_r == CT_NONE && volt_r == CV_NONE))
      else $error("empty slot not decoded");
    AST_FRAME_START: assert property (@(posedge sockLinkClk[g]) disable iff (!linkRstN)
      lkState == LK_ADDR |-> (frameOe_r && !frameOut_r && $past(lkState) == LK_IDLE))
      else $error("frame not asserted at start");
    AST_FRAME_LAST: assert property (@(posedge sockLinkClk[g]) disable iff (!linkRstN)
      (lkState == LK_DATA && left_r == PHASE_W'(1)) |-> frameOut_r)
      else $error("frame low in last phase");
    AST_PHASE_DONE: assert property (@(posedge sockLinkClk[g]) disable iff (!linkRstN)
      (lkState == LK_DATA && frameOut_r && phaseDone) |=> lkState == LK_TURN)
      else $error("last phase did not end");
    AST_NO_TARGET: assert property (@(posedge sockLinkClk[g]) disable iff (!linkRstN)
      lkState == LK_ADDR ##1 (targetSelectNIn[g] && lkState == LK_DATA) [*5]
      |=> (lkState == LK_TURN && lAbort_r))
      else $error("missing target not aborted");
    AST_TARGET_SEL: assert property (@(posedge sockLinkClk[g]) disable iff (!linkRstN)
      lkState == LK_TARGET |-> (devselOe_r && !devselOut_r))
      else $error("target select not driven");
    AST_GRANT_IDLE: assert property (@(posedge sockLinkClk[g]) disable iff (!linkRstN)
      $fell(grantN_r) |-> ($past(busIdle) && $past(lkState) == LK_IDLE))
      else $error("grant during transaction");

    COV_STOP: cover property (@(posedge ref_clk) disable iff (sys_rst)
      crState == CR_STOPPED ##1 crState == CR_RUN);
    COV_XFER: cover property (@(posedge sockLinkClk[g]) disable iff (!linkRstN)
      lkState == LK_DATA ##1 lkState == LK_TURN ##1 ack_r);
    COV_TARGET: cover property (@(posedge sockLinkClk[g]) disable iff (!linkRstN)
      lkState == LK_TARGET ##1 lkState == LK_TURN);
    COV_GRANT: cover property (@(posedge sockLinkClk[g]) disable iff (!linkRstN)
      !grantN_r ##1 !cycleFrameNIn[g]);
  end : gSlot

endmodule : csb_socket_ctrl

`default_nettype wire

// [sim/csb_card_model.sv]
// Purpose: Card side target that claims a started cycle only while its answer input is high
// Assumes: Released lines are pulled high on the bench
// Notes: Zero-wait target; select and ready share one enable
`default_nettype none

module csb_card_model (
  input wire logic clk,
  input wire logic rstN,
  input wire logic answer,
  input wire logic frameN,
  input wire logic irdyN,
  output logic claimOe
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Claim on a started frame, let go after the final phase
  always_ff @(posedge clk) begin
    if (!rstN) begin
      claimOe <= 1'b0;
    end else if (!claimOe && !frameN && answer) begin
      claimOe <= 1'b1;
    end else if (claimOe && frameN && !irdyN) begin
      claimOe <= 1'b0;
    end
  end
endmodule : csb_card_model

`default_nettype wire

// [sim/csb_socket_ctrl_bench.sv]
// Purpose: Self-checking bench of the socket control block
// Assumes: Pull-ups on every shared bus line
// Notes: Slot 1 also covers grant, target select and clock run
`default_nettype none

module csb_socket_ctrl_bench import csb_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic refClk = 0, sysRst = 1, lnk = 0;
  logic [1:0] rstReq, start, answer, aud, cd1, cd2, vs1, vs2, intN, stsIn;
  logic [1:0] reqN, arbEn, hit, stop, crWake, cFrm, initiator_ready_line;
  logic [1:0][3:0] phases;
  wire logic [1:0] busy, done, abort, irq, sts, spk, sclk, srstN, crOut, crOe, gntN;
  wire logic [1:0] fOut, fOe, iOut, iOe, tOut, tOe, dOut, dOe, claim;
  wire logic [1:0][1:0] ctype, cvolt;
  wire logic [1:0] frmN = (~fOe | fOut) & cFrm;
  wire logic [1:0] irdN = (~iOe | iOut) & initiator_ready_line;
  wire logic [1:0] trN = (~tOe | tOut) & ~claim;
  wire logic [1:0] dsN = (~dOe | dOut) & ~claim;
  int fail_count = 0, cmp_count = 0, cycles = 0, phCnt[2], lastCnt[2];
  logic [15:0] lf = 16'hbdaa;
  logic expAbort[$];

  // ==========================================================
  // Clocks, bus and partner
  always #2.5 refClk = ~refClk;
  initial begin
    #7;
    forever #24 lnk = ~lnk;
  end
  csb_socket_ctrl uut (.ref_clk(refClk), .sys_rst(sysRst), .sockLinkClk({2{lnk}}),
    .slotResetReq(rstReq), .clkStopReq(stop), .arbEnable(arbEn), .ownAddrHit(hit),
    .xferStart(start), .xferPhases(phases), .xferBusy(busy), .xferDone(done),
    .xferAbort(abort), .cardIrq(irq), .statusChanged(sts), .speakerOutput(spk),
    .cardType(ctype), .cardVolt(cvolt), .socketClock(sclk), .socketResetN(srstN),
    .clockRunLineIn((~crOe | crOut) & crWake), .clockRunLineOut(crOut), .clockRunLineOe(crOe),
    .socketAudioIn(aud), .cardDetect1N(cd1), .cardDetect2N(cd2), .voltageSense1(vs1),
    .voltageSense2(vs2), .socketInterruptN(intN), .statusChangeLine(stsIn),
    .socketBusRequestN(reqN), .cycleFrameNIn(frmN), .cycleFrameNOut(fOut),
    .cycleFrameNOe(fOe), .initiatorReadyNIn(irdN), .initiatorReadyNOut(iOut),
    .initiatorReadyNOe(iOe), .targetReadyNIn(trN), .targetReadyNOut(tOut),
    .targetReadyNOe(tOe), .targetSelectNIn(dsN), .targetSelectNOut(dOut),
    .targetSelectNOe(dOe), .socketBusGrantN(gntN));
  for (genvar g = 0; g < 2; g++) begin : gCard
    csb_card_model card (.clk(lnk), .rstN(srstN[g]), .answer(answer[g]),
      .frameN(frmN[g]), .irdyN(irdN[g]), .claimOe(claim[g]));
  end

  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsrNext(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsrNext
  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic xfer(input int g, input logic ans, input logic [3:0] n);
    answer[g] = ans;
    phases[g] = n;
    phCnt[g] = 0;
    lastCnt[g] = 0;
    start[g] = 1'b1;
    expAbort.push_back(!ans);
    @(negedge refClk);
    start[g] = 1'b0;
    for (int i = 0; i < 3000 && busy[g] !== 1'b0; i++) @(negedge refClk);
    check("busy", 4'h0, {3'h0, busy[g]});
    check("phases", ans ? (n == 0 ? 4'h1 : n) : 4'h0, 4'(phCnt[g]));
    check("last", {3'h0, ans}, 4'(lastCnt[g]));
  endtask : xfer

  // ==========================================================
  // Watchers and hang limit
  always @(negedge refClk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end
  // Outputs are read half a cycle after they launch, never on the launching edge
  always @(negedge refClk) begin
    for (int g = 0; g < 2; g++) begin
      if (done[g] === 1'b1) begin
        if (expAbort.size() == 0) check("done", 4'h0, 4'h1);
        else check("abort", {3'h0, expAbort.pop_front()}, {3'h0, abort[g]});
      end
    end
  end
  always @(negedge lnk) begin
    for (int g = 0; g < 2; g++) begin
      if (irdN[g] === 1'b0 && trN[g] === 1'b0) begin
        phCnt[g]++;
        if (frmN[g] === 1'b1) lastCnt[g]++;
      end
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    int hi[2];
    {rstReq, start, answer, phases, arbEn, hit, stop} = '0;
    {aud, cd1, cd2, vs1, vs2, intN, stsIn} = '1;
    {reqN, crWake, cFrm, initiator_ready_line} = '1;
    repeat (3) @(negedge refClk);
    sysRst = 1'b0;
    repeat (200) @(negedge refClk);
    for (int k = 0; k < 6; k++) begin
      lf = lfsrNext(lf);
      xfer(k % 2, k != 2 && k != 5, k == 0 ? 4'h0 : lf[3:0]);
    end
    $display("test transfers done");
    hi = '{0, 0};
    repeat (60) begin
      @(negedge refClk);
      for (int g = 0; g < 2; g++) hi[g] += sclk[g];
    end
    check("clock0", 4'h0, 4'(hi[0] - 30));
    check("clock1", 4'h0, 4'(hi[1] - 30));
    $display("test clock done");
    for (int k = 0; k < 8; k++) begin
      lf = lfsrNext(lf);
      {aud, cd1, cd2, vs1, vs2, intN, stsIn} = lf[13:0];
      repeat (5) @(negedge refClk);
      for (int g = 0; g < 2; g++) begin
        check("audio", {3'h0, aud[g]}, {3'h0, spk[g]});
        check("irq", {3'h0, !intN[g]}, {3'h0, irq[g]});
        check("status", {3'h0, stsIn[g]}, {3'h0, sts[g]});
        check("type", {2'h0, (cd1[g] && cd2[g]) ? CT_NONE : (cd1[g] || cd2[g]) ? CT_PARTIAL
          : (vs1[g] ^ vs2[g]) ? CT_32BIT : CT_16BIT}, {2'h0, ctype[g]});
        if (!cd1[g] && !cd2[g]) check("volt", {2'h0, !vs1[g] ? CV_3V3 : !vs2[g] ? CV_LOW
          : CV_5V}, {2'h0, cvolt[g]});
      end
    end
    $display("test sensing done");
    answer[1] = 1'b0;
    {arbEn, hit} = 4'ha;
    @(negedge lnk) reqN = 2'h1;
    repeat (4) @(negedge lnk);
    check("grant", 4'h1, {2'h0, gntN});
    cFrm[1] = 1'b0;
    @(negedge lnk) {cFrm[1], initiator_ready_line[1]} = 2'h2;
    check("select", 4'h0, {3'h0, dsN[1]});
    @(negedge lnk) {initiator_ready_line[1], reqN[1]} = 2'h3;
    repeat (3) @(negedge lnk);
    check("grant", 4'h3, {2'h0, gntN});
    check("select", 4'h1, {3'h0, dsN[1]});
    {arbEn, hit} = 4'h0;
    $display("test grant done");
    @(negedge refClk) stop = 2'h2;
    repeat (80) @(negedge refClk);
    hi = '{0, 0};
    repeat (12) begin
      @(negedge refClk);
      hi[1] += sclk[1];
    end
    check("parked", 4'h0, 4'(hi[1]));
    check("runOe", 4'h0, {3'h0, crOe[1]});
    crWake[1] = 1'b0;
    repeat (10) @(negedge refClk);
    hi = '{0, 0};
    repeat (60) begin
      @(negedge refClk);
      hi[1] += sclk[1];
    end
    check("woken", 4'h0, 4'(hi[1] - 30));
    {stop, crWake} = 4'h3;
    $display("test clock run done");
    rstReq = 2'h1;
    repeat (30) @(negedge refClk);
    check("resetN", 4'h2, {2'h0, srstN});
    check("release", 4'h0, {fOe[0], iOe[0], tOe[0], dOe[0]});
    rstReq = 2'h0;
    repeat (150) @(negedge refClk);
    check("resetN", 4'h3, {2'h0, srstN});
    xfer(0, 1'b1, 4'h2);
    $display("test reset done");
    close_out();
  end
endmodule : csb_socket_ctrl_bench

`default_nettype wire
